/* inc/clksel_consts.vh */
/*
 * Constants for the reference input selector and holdover averager.
 * Assumes inclusion by bare name from the rtl files.
 */
`ifndef CLKSEL_CONSTS_VH
`define CLKSEL_CONSTS_VH
`define NUM_INPUTS 4
`define FB_INPUT 2'h3
`define HIST_DEPTH 120
`define HIST_AW 7
`define HIST_SECONDS 120
`define CLK_MHZ 100
`define FREQ_W 24
`define SUM_W 31
`endif

/* rtl/holdover_history.v */
/*
 * Frequency history store with a windowed average for holdover.
 * Assumes one sample strobe per history slot from the host clocking.
 */
`timescale 1ns/100ps
`include "clksel_consts.vh"
module holdover_history (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire i_sample_stb,
    input wire i_record_en,
    input wire [`FREQ_W-1:0] i_freq_word,
    input wire [`HIST_AW-1:0] i_avg_len,
    input wire [`HIST_AW-1:0] i_avg_delay,
    input wire i_start,
    output reg [`FREQ_W-1:0] o_avg_q,
    output reg o_avg_valid_q
);
    reg [`FREQ_W-1:0] mem_q [0:`HIST_DEPTH-1];
    reg [`HIST_AW-1:0] wr_q;
    reg [`HIST_AW-1:0] rd_q;
    reg [`HIST_AW-1:0] cnt_q;
    reg [`HIST_AW-1:0] fill_q;
    reg [`SUM_W-1:0] sum_q;
    reg [`HIST_AW-1:0] len_q;
    reg busy_q;
    wire [`HIST_AW-1:0] eff_len;
    wire [`SUM_W-1:0] quot;

    function [`HIST_AW-1:0] wrap_back;
        input [`HIST_AW-1:0] p;
        input [`HIST_AW-1:0] n;
        reg [31:0] t;
        begin
            t = p + `HIST_DEPTH - n;
            if (p >= n) begin
                wrap_back = p - n;
            end else begin
                wrap_back = t[`HIST_AW-1:0];
            end
        end
    endfunction

    // Window never shorter than one sample
    assign eff_len = (i_avg_len == 7'h00) ? 7'h01 : i_avg_len;
    // Mean of words never exceeds one word, upper bits stay zero
    assign quot = sum_q / len_q;

    always @(posedge i_mclk) begin
        if (i_sample_stb && i_record_en) begin
            mem_q[wr_q] <= i_freq_word;
        end
    end

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            wr_q <= 7'h00;
            fill_q <= 7'h00;
            rd_q <= 7'h00;
            cnt_q <= 7'h00;
            sum_q <= 31'h0;
            len_q <= 7'h01;
            busy_q <= 1'b0;
            o_avg_q <= 24'h0;
            o_avg_valid_q <= 1'b0;
        end else begin
            if (i_sample_stb && i_record_en) begin
                wr_q <= (wr_q == `HIST_DEPTH - 1) ? 7'h00 : wr_q + 7'h01;
                if (fill_q != `HIST_DEPTH) begin
                    fill_q <= fill_q + 7'h01;
                end
            end
            if (i_start && !busy_q) begin
                // Skip the newest samples, they may be corrupt
                rd_q <= wrap_back(wr_q, i_avg_delay + 7'h01);
                len_q <= eff_len;
                cnt_q <= 7'h00;
                sum_q <= 31'h0;
                busy_q <= 1'b1;
                o_avg_valid_q <= 1'b0;
            end else if (busy_q) begin
                if (cnt_q == len_q) begin
                    busy_q <= 1'b0;
                    o_avg_q <= quot[`FREQ_W-1:0];
                    o_avg_valid_q <= (fill_q != 7'h00);
                end else begin
                    sum_q <= sum_q + {7'h00, mem_q[rd_q]};
                    rd_q <= wrap_back(rd_q, 7'h01);
                    cnt_q <= cnt_q + 7'h01;
                end
            end
        end
    end
endmodule

/* rtl/input_clock_select_holdover.v */
/*
 * Reference input selector with automatic priority and manual modes,
 * holdover control and holdover frequency average.
 * Assumes alarm monitors and config pins are asynchronous to i_mclk.
 */
`timescale 1ns/100ps
`include "clksel_consts.vh"
module input_clock_select_holdover (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire [3:0] i_signal_loss_alarm,
    input wire [3:0] i_frequency_range_alarm,
    input wire i_pll_lock_loss,
    input wire [3:0] i_signal_loss_mask,
    input wire [3:0] i_frequency_range_mask,
    input wire [7:0] i_priority_rank,
    input wire i_revertive,
    input wire i_auto_mode,
    input wire i_manual_from_reg,
    input wire [1:0] i_sel_pins,
    input wire [1:0] i_sel_reg,
    input wire i_zero_delay,
    input wire i_sample_stb,
    input wire [`FREQ_W-1:0] i_freq_word,
    input wire [`HIST_AW-1:0] i_avg_len,
    input wire [`HIST_AW-1:0] i_avg_delay,
    output reg [1:0] o_sel_input_q,
    output reg o_holdover_q,
    output reg o_lock_loss_indication_q,
    output reg [3:0] o_input_valid_q,
    output reg [`FREQ_W-1:0] o_holdover_freq_q,
    output reg o_holdover_freq_valid_q
);
    // ***************************************************
    // Synchronisers
    // ***************************************************
    reg [3:0] los_m_q, los_s_q, oof_m_q, oof_s_q;
    reg [1:0] pin_m_q, pin_s_q;
    reg lol_m_q, lol_s_q;

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            los_m_q <= 4'hf;
            los_s_q <= 4'hf;
            oof_m_q <= 4'hf;
            oof_s_q <= 4'hf;
            pin_m_q <= 2'h0;
            pin_s_q <= 2'h0;
            lol_m_q <= 1'b1;
            lol_s_q <= 1'b1;
        end else begin
            los_m_q <= i_signal_loss_alarm;
            los_s_q <= los_m_q;
            oof_m_q <= i_frequency_range_alarm;
            oof_s_q <= oof_m_q;
            pin_m_q <= i_sel_pins;
            pin_s_q <= pin_m_q;
            lol_m_q <= i_pll_lock_loss;
            lol_s_q <= lol_m_q;
        end
    end

    // ***************************************************
    // Validity and priority
    // ***************************************************
    reg [3:0] valid_d;
    reg [1:0] best_d;
    reg any_d;
    reg [1:0] man_d;
    reg [1:0] best_rank;
    integer k;

    function [1:0] rank_of;
        input [7:0] ranks;
        input [1:0] idx;
        begin
            rank_of = ranks[idx*2 +: 2];
        end
    endfunction

    always @* begin
        valid_d = 4'h0;
        best_d = 2'h0;
        any_d = 1'b0;
        best_rank = 2'h3;
        for (k = 0; k < `NUM_INPUTS; k = k + 1) begin
            valid_d[k] = !(los_s_q[k] & i_signal_loss_mask[k]) &&
                !(oof_s_q[k] & i_frequency_range_mask[k]);
        end
        if (i_zero_delay) begin
            valid_d[`FB_INPUT] = 1'b0;
        end
        // Rank 0 is highest; strict compare keeps lower index on ties
        for (k = 0; k < `NUM_INPUTS; k = k + 1) begin
            if (valid_d[k] && (!any_d ||
                rank_of(i_priority_rank, k[1:0]) < best_rank)) begin
                any_d = 1'b1;
                best_d = k[1:0];
                best_rank = rank_of(i_priority_rank, k[1:0]);
            end
        end
        man_d = i_manual_from_reg ? i_sel_reg : pin_s_q;
    end

    // ***************************************************
    // Selection state machine
    // ***************************************************
    localparam ST_TRACK = 2'b01;
    localparam ST_HOLD = 2'b10;
    reg [1:0] state_q;
    reg [3:0] valid_q;
    wire man_ok;
    wire cur_ok;

    // Manual choice of the feedback input is unusable in zero delay mode
    assign man_ok = valid_q[man_d];
    assign cur_ok = valid_q[o_sel_input_q];

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            valid_q <= 4'h0;
            state_q <= ST_HOLD;
            o_sel_input_q <= 2'h0;
            o_holdover_q <= 1'b1;
            o_lock_loss_indication_q <= 1'b1;
            o_input_valid_q <= 4'h0;
        end else begin
            valid_q <= valid_d;
            o_input_valid_q <= valid_q;
            // Holdover ignores lock loss; it only forces the flag on
            o_lock_loss_indication_q <= lol_s_q || (state_q == ST_HOLD);
            case (state_q)
                ST_TRACK: begin
                    if (!i_auto_mode) begin
                        o_sel_input_q <= man_d;
                        if (!man_ok) begin
                            state_q <= ST_HOLD;
                            o_holdover_q <= 1'b1;
                        end
                    end else if (!any_d) begin
                        state_q <= ST_HOLD;
                        o_holdover_q <= 1'b1;
                    end else if (i_revertive || !cur_ok) begin
                        o_sel_input_q <= best_d;
                    end
                end
                ST_HOLD: begin
                    if (!i_auto_mode) begin
                        o_sel_input_q <= man_d;
                        if (man_ok) begin
                            state_q <= ST_TRACK;
                            o_holdover_q <= 1'b0;
                        end
                    end else if (any_d) begin
                        o_sel_input_q <= best_d;
                        state_q <= ST_TRACK;
                        o_holdover_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_HOLD;
                    o_holdover_q <= 1'b1;
                end
            endcase
        end
    end

    // ***************************************************
    // Holdover history
    // ***************************************************
    reg hold_prev_q;
    wire [`FREQ_W-1:0] avg_w;
    wire avg_valid_w;

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            hold_prev_q <= 1'b1;
            o_holdover_freq_q <= 24'h0;
            o_holdover_freq_valid_q <= 1'b0;
        end else begin
            hold_prev_q <= o_holdover_q;
            o_holdover_freq_q <= avg_w;
            o_holdover_freq_valid_q <= avg_valid_w && o_holdover_q;
        end
    end

    // Writes stop in holdover and while lock is lost, so the average
    // only holds samples taken while tracking a good input
    holdover_history i_holdover_history (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_sample_stb(i_sample_stb),
        .i_record_en(!o_holdover_q && !lol_s_q),
        .i_freq_word(i_freq_word),
        .i_avg_len(i_avg_len),
        .i_avg_delay(i_avg_delay),
        .i_start(o_holdover_q && !hold_prev_q),
        .o_avg_q(avg_w),
        .o_avg_valid_q(avg_valid_w)
    );
endmodule

/* tb/ref_sources.sv */
/* Reference source model: per-input alarm monitors, select pins and
   history sample strobe. Assumes the bench commands each failure. */
`timescale 1ns/100ps
module ref_sources (
    input wire i_mclk,
    input wire [3:0] i_lose,
    input wire [3:0] i_drift,
    input wire [1:0] i_pick,
    output reg [3:0] o_signal_loss_alarm = 4'h0,
    output reg [3:0] o_frequency_range_alarm = 4'h0,
    output reg [1:0] o_sel_pins = 2'h0,
    output reg o_sample_stb = 1'b0
);
    reg [1:0] div_q = 2'h0;
    // ****************
    // Monitors
    // ****************
    // Every input watched, selected or not
    always @(posedge i_mclk) begin
        o_signal_loss_alarm <= i_lose;
        o_frequency_range_alarm <= i_drift;
        o_sel_pins <= i_pick;
        div_q <= div_q + 2'h1;
        o_sample_stb <= (div_q == 2'h0);
    end
endmodule

/* tb/input_clock_select_holdover_props.sv */
/* Checker for the input selector; sees only the top ports.
   Assumes one clock and synchronous reset. */
`timescale 1ns/100ps
module clksel_props (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire [3:0] i_signal_loss_alarm,
    input wire [3:0] i_frequency_range_alarm,
    input wire [3:0] i_signal_loss_mask,
    input wire [3:0] i_frequency_range_mask,
    input wire [7:0] i_priority_rank,
    input wire i_revertive,
    input wire i_auto_mode,
    input wire i_manual_from_reg,
    input wire [1:0] i_sel_pins,
    input wire [1:0] i_sel_reg,
    input wire i_zero_delay,
    input wire [1:0] o_sel_input_q,
    input wire o_holdover_q,
    input wire o_lock_loss_indication_q,
    input wire [3:0] o_input_valid_q,
    input wire o_holdover_freq_valid_q
);
    wire [3:0] bad = (i_signal_loss_alarm & i_signal_loss_mask) |
        (i_frequency_range_alarm & i_frequency_range_mask);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // Ties go to the lower index
    function automatic [1:0] best(input [3:0] v, input [7:0] r);
        reg [2:0] m;
        m = 3'h4;
        best = 2'h0;
        for (int k = 0; k < 4; k++) begin
            if (v[k] && {1'b0, r[2*k+:2]} < m) begin
                m = {1'b0, r[2*k+:2]};
                best = k[1:0];
            end
        end
    endfunction
    // ****************
    // Properties
    // ****************
    sequence cfg_still;
        $stable(i_signal_loss_alarm) && $stable(i_frequency_range_alarm)
        && $stable(bad) && $stable(i_zero_delay);
    endsequence
    sequence auto_still;
        i_auto_mode && $stable(o_input_valid_q) &&
        $stable(i_priority_rank) && $stable(i_revertive);
    endsequence
    AST_VALID: assert property (cfg_still [*5] |->
        o_input_valid_q == (~bad & {~i_zero_delay, 3'h7}))
        else $error("input validity wrong");
    // Valid outputs trail the selection decision by one cycle
    AST_HOLD_AUTO: assert property (auto_still [*3] |->
        $past(o_holdover_q) == (o_input_valid_q == 4'h0))
        else $error("auto holdover wrong");
    AST_REV_SEL: assert property (auto_still [*3] ##0
        (i_revertive && o_input_valid_q != 4'h0) |->
        $past(o_sel_input_q) == best(o_input_valid_q, i_priority_rank))
        else $error("revertive pick wrong");
    AST_NONREV_KEEP: assert property ((i_auto_mode && !i_revertive &&
        !o_holdover_q) ##1 (i_auto_mode && !i_revertive &&
        o_input_valid_q[$past(o_sel_input_q)]) |-> $stable(o_sel_input_q))
        else $error("non-revert left valid input");
    AST_MAN_REG: assert property ((!i_auto_mode && i_manual_from_reg)
        ##1 (!i_auto_mode && i_manual_from_reg) |->
        o_sel_input_q == $past(i_sel_reg))
        else $error("register select wrong");
    AST_MAN_PIN: assert property ((!i_auto_mode && !i_manual_from_reg &&
        $stable(i_sel_pins)) [*4] |-> o_sel_input_q == i_sel_pins)
        else $error("pin select wrong");
    AST_MAN_HOLD: assert property ((!i_auto_mode &&
        $stable(o_sel_input_q) && $stable(o_input_valid_q)) [*2] |->
        o_holdover_q == !o_input_valid_q[o_sel_input_q])
        else $error("manual holdover wrong");
    AST_HOLD_LOL: assert property (o_holdover_q ##1 o_holdover_q |->
        o_lock_loss_indication_q)
        else $error("lock loss low in holdover");
    AST_FREQ_VALID: assert property ($rose(o_holdover_freq_valid_q) |->
        $past(o_holdover_q))
        else $error("average valid outside holdover");
endmodule
bind input_clock_select_holdover clksel_props i_props (.i_mclk, .i_sys_rst,
    .i_signal_loss_alarm, .i_frequency_range_alarm, .i_signal_loss_mask,
    .i_frequency_range_mask, .i_priority_rank, .i_revertive, .i_auto_mode,
    .i_manual_from_reg, .i_sel_pins, .i_sel_reg, .i_zero_delay,
    .o_sel_input_q, .o_holdover_q, .o_lock_loss_indication_q,
    .o_input_valid_q, .o_holdover_freq_valid_q);

/* tb/input_clock_select_holdover_test.sv */
/* Self-checking bench for the input selector and holdover.
   Assumes the source model and checker compiled before it. */
`timescale 1ns/100ps
`include "clksel_consts.vh"
module input_clock_select_holdover_test;
    reg [`FREQ_W-1:0] fw = 24'h3a5c71, last_rec = 24'h0;
    reg i_mclk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] sig_fail = 4'h0, freq_fail = 4'h0, lm = 4'hf, fm = 4'hf;
    reg [7:0] rank = 8'he4;
    reg rev = 1'b1, auto = 1'b1, from_reg = 1'b0, zd = 1'b0, pll = 1'b0;
    reg [1:0] pick = 2'h0, sel_reg = 2'h0;
    wire [3:0] sla, fra, valid;
    wire [1:0] pins, sel;
    wire stb, hold, ll_ind, hfv;
    wire [`FREQ_W-1:0] hfreq;
    integer failures = 0, cmp_count = 0, cyc = 0, k;
    ref_sources i_ref_sources (.i_mclk(i_mclk), .i_lose(sig_fail),
        .i_drift(freq_fail), .i_pick(pick), .o_signal_loss_alarm(sla),
        .o_frequency_range_alarm(fra), .o_sel_pins(pins),
        .o_sample_stb(stb));
    input_clock_select_holdover i_input_clock_select_holdover (
        .i_mclk(i_mclk), .i_sys_rst(rst), .i_signal_loss_alarm(sla),
        .i_frequency_range_alarm(fra), .i_pll_lock_loss(pll),
        .i_signal_loss_mask(lm), .i_frequency_range_mask(fm),
        .i_priority_rank(rank), .i_revertive(rev), .i_auto_mode(auto),
        .i_manual_from_reg(from_reg), .i_sel_pins(pins),
        .i_sel_reg(sel_reg), .i_zero_delay(zd), .i_sample_stb(stb),
        .i_freq_word(fw), .i_avg_len(7'h04), .i_avg_delay(7'h02),
        .o_sel_input_q(sel), .o_holdover_q(hold),
        .o_lock_loss_indication_q(ll_ind), .o_input_valid_q(valid),
        .o_holdover_freq_q(hfreq), .o_holdover_freq_valid_q(hfv));
    // ****************
    // Tasks
    // ****************
    initial forever #5 i_mclk = ~i_mclk;
    task end_of_test;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Ceiling well above the ~270 cycles the sequence needs
    always @(posedge i_mclk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    task cmp(input string what, input [23:0] exp, input [23:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask
    // Ramp the word per sample so window and delay show in the mean
    always @(posedge i_mclk) begin
        if (stb) begin
            fw <= fw + 24'h1;
        end
        if (stb && !hold) begin
            last_rec <= fw;
        end
    end
    // Long enough for sync, validity and state stages
    task settle;
        repeat (8) @(posedge i_mclk);
        #1;
    endtask
    task go(input [3:0] l, input [3:0] o);
        @(posedge i_mclk);
        sig_fail <= l;
        freq_fail <= o;
        settle;
    endtask
    task want(input [1:0] s, input h);
        cmp("sel", s, sel);
        cmp("hold", h, hold);
    endtask
    // ****************
    // Sequence
    // ****************
    initial begin
        repeat (8) @(posedge i_mclk);
        rst <= 1'b0;
        go(4'h0, 4'h0); cmp("valid", 4'hf, valid); want(2'h0, 1'b0);
        go(4'h1, 4'h0); want(2'h1, 1'b0);
        go(4'h1, 4'h2); want(2'h2, 1'b0);
        go(4'h0, 4'h2); want(2'h0, 1'b0);
        @(posedge i_mclk); rev <= 1'b0;
        go(4'h1, 4'h2); want(2'h2, 1'b0);
        go(4'h0, 4'h2); want(2'h2, 1'b0);
        @(posedge i_mclk); lm <= 4'he; fm <= 4'hd;
        go(4'h1, 4'h2); cmp("valid", 4'hf, valid);
        @(posedge i_mclk); lm <= 4'hf; fm <= 4'hf; rev <= 1'b1;
        rank <= 8'h1b;
        go(4'h0, 4'h0); want(2'h3, 1'b0);
        @(posedge i_mclk); zd <= 1'b1;
        go(4'h0, 4'h0); cmp("valid", 4'h7, valid); want(2'h2, 1'b0);
        @(posedge i_mclk); rank <= 8'h00;
        go(4'h0, 4'h0); want(2'h0, 1'b0);
        @(posedge i_mclk); pll <= 1'b1;
        go(4'h0, 4'h0); want(2'h0, 1'b0); cmp("lock_loss", 1, ll_ind);
        @(posedge i_mclk); pll <= 1'b0;
        // Six clean samples before the failure: window plus skipped part
        repeat (3) settle;
        go(4'hf, 4'h0); cmp("hold", 1, hold); cmp("lock_loss", 1, ll_ind);
        settle;
        settle;
        // Four samples ending two back: mean of newest-2 .. newest-5
        cmp("fvalid", 1, hfv);
        cmp("freq", last_rec - 24'h4, hfreq);
        go(4'hd, 4'h0); want(2'h1, 1'b0);
        @(posedge i_mclk); auto <= 1'b0; zd <= 1'b0;
        go(4'h0, 4'h0);
        for (k = 0; k < 8; k = k + 1) begin
            @(posedge i_mclk);
            from_reg <= (k < 4);
            sel_reg <= k[1:0];
            pick <= ~k[1:0];
            settle;
            want((k < 4) ? k[1:0] : ~k[1:0], 1'b0);
        end
        go(4'h1, 4'h0); want(2'h0, 1'b1);
        go(4'h0, 4'h0); want(2'h0, 1'b0);
        end_of_test;
    end
endmodule
